// ### include/adc_cfg.svh
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH
// How it works
// - select-high trigger rise: convert, float output
// - host holds trigger high through conversion, readback
// - trigger and select both low: drive low
// - no-busy select returns high inside conversion window
// - no-busy: select low shows msb, 16 edges
// - busy mode: select low until busy shows
// - busy mode: ready low flag, 17 edges
// - select low at trigger rise: chain mode
// - chain host pulses trigger low then high
// - serial clock level at rise picks busy
// - chain mode never floats the output
// - chain: msb at end, shift through
// - chain host gives sixteen edges per device
// - chain busy needs own done and upstream enable
// - busy bit not chained: one extra edge
// - select high picks chip-select, low chain
// - no-busy host times out maximum conversion

`define RESULT_BITS 16
`define RESULT_MSB 15
`define EDGE_W 6
`define TIMER_W 16
`define CLK_PERIOD_NS 5
`define CONV_TIME_NS 1500
`define CONV_MAX_NS 2000
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_MAX_CYCLES ((`CONV_MAX_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCLK_HALF_CYCLES 8
`define SETTLE_CYCLES 8
`define CHAIN_LEN 2
`define FLAG_EDGES 1
`endif

// ### include/adc_pkg.sv
package adc_pkg;
  typedef enum logic [2:0] {
    DEV_IDLE,
    DEV_CONVERT,
    DEV_CS_WAIT,
    DEV_CS_READ,
    DEV_CHAIN_READ
  } dev_state_type;

  typedef enum logic [3:0] {
    HOST_IDLE,
    HOST_TRIG_LOW,
    HOST_TRIG_HIGH,
    HOST_WAIT_CONV,
    HOST_WAIT_BUSY,
    HOST_SELECT,
    HOST_CLK_HI,
    HOST_CLK_LO
  } host_state_type;

  typedef enum logic [1:0] {
    MODE_CS_NOBUSY,
    MODE_CS_BUSY,
    MODE_CHAIN_NOBUSY,
    MODE_CHAIN_BUSY
  } mode_type;
endpackage : adc_pkg

// ### include/adc_link_if.sv
interface adc_link_if;
  logic conv_trigger;
  logic sclk;
  logic chain_select_in;
  logic result_out;
  logic result_out_oe;
  logic result_level;

  // external pullup holds the line high while the device floats it
  assign result_level = result_out_oe ? result_out : 1'b1;

  modport device (
    input conv_trigger,
    input sclk,
    input chain_select_in,
    output result_out,
    output result_out_oe
  );

  modport host (
    output conv_trigger,
    output sclk,
    output chain_select_in,
    input result_level
  );
endinterface : adc_link_if

// ### core/adc_device.sv
`include "adc_cfg.svh"

module adc_device #(
  parameter int CONV_CYCLES = `CONV_CYCLES
) (
  input wire logic clk_sys_i, // system clock
  input wire logic rst_n_i, // sync reset, active low
  input wire logic ce_i, // clock enable, freezes state when low
  input wire logic [`RESULT_MSB:0] sample_i, // result from the converter core
  output logic converting_o, // high while a conversion runs
  adc_link_if.device link // pins toward host or neighbours
);

  logic [2:0] conv_sync;
  logic [2:0] sclk_sync;
  logic [2:0] sel_sync;
  logic [2:0] next_conv_sync;
  logic [2:0] next_sclk_sync;
  logic [2:0] next_sel_sync;
  logic conv_s;
  logic sclk_s;
  logic sel_s;
  logic conv_rise;
  logic sclk_fall;

  adc_pkg::dev_state_type state;
  adc_pkg::dev_state_type next_state;
  logic chain_mode;
  logic next_chain_mode;
  logic busy_mode;
  logic next_busy_mode;
  logic flag_pending;
  logic next_flag_pending;
  logic busy_seen;
  logic next_busy_seen;
  logic [`RESULT_MSB:0] shreg;
  logic [`RESULT_MSB:0] next_shreg;
  logic [`TIMER_W-1:0] timer;
  logic [`TIMER_W-1:0] next_timer;
  logic [`EDGE_W-1:0] edge_cnt;
  logic [`EDGE_W-1:0] next_edge_cnt;
  logic [`EDGE_W-1:0] last_edge;
  logic converting;
  logic next_converting;
  logic out;
  logic next_out;
  logic oe;
  logic next_oe;
  logic start;

  // pins are asynchronous: bit 0 feeds only bit 1, bit 2 is the edge history
  always_comb
  begin
    next_conv_sync = {conv_sync[1:0], link.conv_trigger};
    next_sclk_sync = {sclk_sync[1:0], link.sclk};
    next_sel_sync = {sel_sync[1:0], link.chain_select_in};
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      conv_sync <= 3'h0;
      sclk_sync <= 3'h0;
      sel_sync <= 3'h0;
    end
    else if (ce_i)
    begin
      conv_sync <= next_conv_sync;
      sclk_sync <= next_sclk_sync;
      sel_sync <= next_sel_sync;
    end
  end

  // levels and edges seen after the second stage
  assign conv_s = conv_sync[1];
  assign sclk_s = sclk_sync[1];
  assign sel_s = sel_sync[1];
  assign conv_rise = conv_sync[1] & ~conv_sync[2];
  assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];

  // a busy flag costs one extra falling edge before the data
  assign last_edge = busy_mode ? `EDGE_W'(`RESULT_BITS + `FLAG_EDGES) : `EDGE_W'(`RESULT_BITS);

  // a trigger rise in idle or in select-mode wait or readout starts a new one; conversion and chain readout ignore it
  assign start = conv_rise && (state == adc_pkg::DEV_IDLE || state == adc_pkg::DEV_CS_WAIT ||
                               state == adc_pkg::DEV_CS_READ);

  // sequencing of conversion and readout
  always_comb
  begin
    next_state = state;
    next_chain_mode = chain_mode;
    next_busy_mode = busy_mode;
    next_flag_pending = flag_pending;
    next_busy_seen = busy_seen;
    next_shreg = shreg;
    next_timer = timer;
    next_edge_cnt = edge_cnt;
    next_converting = converting;
    case (state)
      adc_pkg::DEV_IDLE:
      begin
        next_state = state;
      end
      adc_pkg::DEV_CONVERT:
      begin
        next_timer = timer + `TIMER_W'(1);
        if (timer == `TIMER_W'(CONV_CYCLES - 1))
        begin
          next_shreg = sample_i;
          next_converting = 1'b0;
          next_edge_cnt = `EDGE_W'(0);
          next_busy_seen = 1'b0;
          if (chain_mode)
          begin
            next_flag_pending = busy_mode;
            next_state = adc_pkg::DEV_CHAIN_READ;
          end
          else if (!sel_s)
          begin
            // select low at completion asks for the ready flag
            next_busy_mode = 1'b1;
            next_flag_pending = 1'b1;
            next_state = adc_pkg::DEV_CS_READ;
          end
          else
          begin
            next_flag_pending = 1'b0;
            next_state = adc_pkg::DEV_CS_WAIT;
          end
        end
      end
      adc_pkg::DEV_CS_WAIT:
      begin
        if (!sel_s)
        begin
          next_state = adc_pkg::DEV_CS_READ;
        end
      end
      adc_pkg::DEV_CS_READ:
      begin
        if (sclk_fall)
        begin
          next_edge_cnt = edge_cnt + `EDGE_W'(1);
          if (edge_cnt == last_edge - `EDGE_W'(1))
          begin
            next_state = adc_pkg::DEV_IDLE;
          end
          else if (flag_pending)
          begin
            next_flag_pending = 1'b0;
          end
          else
          begin
            next_shreg = {shreg[`RESULT_MSB-1:0], 1'b0};
          end
        end
      end
      adc_pkg::DEV_CHAIN_READ:
      begin
        if (!conv_s)
        begin
          // next acquisition; output stays driven
          next_state = adc_pkg::DEV_IDLE;
        end
        else if (flag_pending)
        begin
          if (sel_s)
          begin
            next_busy_seen = 1'b1;
          end
          if (sclk_fall && busy_seen)
          begin
            next_flag_pending = 1'b0;
          end
        end
        else if (sclk_fall)
        begin
          next_shreg = {shreg[`RESULT_MSB-1:0], sel_s};
        end
      end
      default:
      begin
        next_state = adc_pkg::DEV_IDLE;
      end
    endcase
    if (start)
    begin
      next_state = adc_pkg::DEV_CONVERT;
      next_converting = 1'b1;
      next_timer = `TIMER_W'(0);
      next_chain_mode = ~sel_s;
      next_busy_mode = ~sel_s & sclk_s;
      next_flag_pending = 1'b0;
    end
  end

  // output pin follows the next state so it lands with it
  always_comb
  begin
    next_out = 1'b0;
    next_oe = 1'b0;
    case (next_state)
      adc_pkg::DEV_CONVERT:
      begin
        next_oe = next_chain_mode;
      end
      adc_pkg::DEV_CS_READ:
      begin
        next_oe = 1'b1;
        next_out = next_flag_pending ? 1'b0 : next_shreg[`RESULT_MSB];
      end
      adc_pkg::DEV_CHAIN_READ:
      begin
        next_oe = 1'b1;
        next_out = next_flag_pending ? next_busy_seen : next_shreg[`RESULT_MSB];
      end
      default:
      begin
        if (!conv_s && !sel_s)
        begin
          // low here arms chain mode in the next device down
          next_oe = 1'b1;
          next_out = 1'b0;
        end
        else
        begin
          next_oe = next_chain_mode;
          next_out = next_chain_mode & next_shreg[`RESULT_MSB];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      state <= adc_pkg::DEV_IDLE;
      chain_mode <= 1'b0;
      busy_mode <= 1'b0;
      flag_pending <= 1'b0;
      busy_seen <= 1'b0;
      shreg <= 16'h0000;
      timer <= 16'h0000;
      edge_cnt <= 6'h00;
      converting <= 1'b0;
      out <= 1'b0;
      oe <= 1'b0;
    end
    else if (ce_i)
    begin
      state <= next_state;
      chain_mode <= next_chain_mode;
      busy_mode <= next_busy_mode;
      flag_pending <= next_flag_pending;
      busy_seen <= next_busy_seen;
      shreg <= next_shreg;
      timer <= next_timer;
      edge_cnt <= next_edge_cnt;
      converting <= next_converting;
      out <= next_out;
      oe <= next_oe;
    end
  end

  // all pins straight from flops
  assign link.result_out = out;
  assign link.result_out_oe = oe;
  assign converting_o = converting;

endmodule : adc_device

// ### core/adc_host.sv
`include "adc_cfg.svh"

module adc_host #(
  parameter int CONV_MAX_CYCLES = `CONV_MAX_CYCLES
) (
  input wire logic clk_sys_i, // system clock
  input wire logic rst_n_i, // sync reset, active low
  input wire logic ce_i, // clock enable, freezes state when low
  input wire logic start_i, // one-cycle request for a conversion
  input wire adc_pkg::mode_type mode_i, // readout mode, taken with start
  output logic busy_o, // high while a transfer runs
  output logic [`RESULT_MSB:0] word_o, // last received result word
  output logic word_valid_o, // one-cycle pulse per word
  adc_link_if.host link // pins toward the converter
);

  logic [1:0] res_sync;
  logic [1:0] next_res_sync;
  logic res_s;
  adc_pkg::host_state_type state;
  adc_pkg::host_state_type next_state;
  adc_pkg::mode_type mode;
  adc_pkg::mode_type next_mode;
  logic [`TIMER_W-1:0] timer;
  logic [`TIMER_W-1:0] next_timer;
  logic [`EDGE_W-1:0] edges;
  logic [`EDGE_W-1:0] next_edges;
  logic [`EDGE_W-1:0] total;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [`RESULT_MSB:0] shift;
  logic [`RESULT_MSB:0] next_shift;
  logic [`RESULT_MSB:0] next_word;
  logic next_word_valid;
  logic next_busy;
  logic conv;
  logic next_conv;
  logic sclk;
  logic next_sclk;
  logic sel;
  logic next_sel;
  logic is_chain;
  logic is_busy;

  // returning data line is asynchronous here
  assign next_res_sync = {res_sync[0], link.result_level};
  assign res_s = res_sync[1];
  assign is_chain = mode == adc_pkg::MODE_CHAIN_NOBUSY || mode == adc_pkg::MODE_CHAIN_BUSY;
  assign is_busy = mode == adc_pkg::MODE_CS_BUSY || mode == adc_pkg::MODE_CHAIN_BUSY;
  // edge budget per transfer
  assign total = (is_chain ? `EDGE_W'(`RESULT_BITS * `CHAIN_LEN) : `EDGE_W'(`RESULT_BITS)) +
                 (is_busy ? `EDGE_W'(`FLAG_EDGES) : `EDGE_W'(0));

  // transfer sequencer; settle gaps cover the device's input synchronisers
  always_comb
  begin
    next_state = state;
    next_mode = mode;
    next_timer = timer + `TIMER_W'(1);
    next_edges = edges;
    next_bitcnt = bitcnt;
    next_shift = shift;
    next_word = word_o;
    next_word_valid = 1'b0;
    next_busy = busy_o;
    next_conv = conv;
    next_sclk = sclk;
    next_sel = sel;
    case (state)
      adc_pkg::HOST_IDLE:
      begin
        if (start_i)
        begin
          next_mode = mode_i;
          next_busy = 1'b1;
          next_conv = 1'b0;
          next_sel = !(mode_i == adc_pkg::MODE_CHAIN_NOBUSY ||
                       mode_i == adc_pkg::MODE_CHAIN_BUSY);
          next_sclk = mode_i == adc_pkg::MODE_CHAIN_BUSY;
          next_timer = `TIMER_W'(0);
          next_edges = `EDGE_W'(0);
          next_bitcnt = 4'h0;
          next_state = adc_pkg::HOST_TRIG_LOW;
        end
      end
      adc_pkg::HOST_TRIG_LOW:
      begin
        if (timer == `TIMER_W'(`SETTLE_CYCLES - 1))
        begin
          next_conv = 1'b1;
          next_timer = `TIMER_W'(0);
          next_state = adc_pkg::HOST_TRIG_HIGH;
        end
      end
      adc_pkg::HOST_TRIG_HIGH:
      begin
        if (timer == `TIMER_W'(`SETTLE_CYCLES - 1))
        begin
          next_sclk = 1'b0;
          if (mode == adc_pkg::MODE_CS_BUSY)
          begin
            next_sel = 1'b0;
          end
          if (mode == adc_pkg::MODE_CHAIN_BUSY)
          begin
            next_sel = 1'b1; // busy enable into the chain head
          end
          next_timer = `TIMER_W'(0);
          next_state = is_busy ? adc_pkg::HOST_WAIT_BUSY : adc_pkg::HOST_WAIT_CONV;
        end
      end
      adc_pkg::HOST_WAIT_CONV:
      begin
        // select stays high across the whole conversion window in select mode, and low in chain mode
        if (timer == `TIMER_W'(CONV_MAX_CYCLES - 1))
        begin
          next_timer = `TIMER_W'(0);
          if (mode == adc_pkg::MODE_CS_NOBUSY)
          begin
            next_sel = 1'b0;
            next_state = adc_pkg::HOST_SELECT;
          end
          else
          begin
            next_sclk = 1'b1;
            next_state = adc_pkg::HOST_CLK_HI;
          end
        end
      end
      adc_pkg::HOST_WAIT_BUSY:
      begin
        // no timeout: a dead device leaves the host waiting
        next_timer = `TIMER_W'(0);
        if (res_s == is_chain)
        begin
          next_sclk = 1'b1;
          next_state = adc_pkg::HOST_CLK_HI;
        end
      end
      adc_pkg::HOST_SELECT:
      begin
        if (timer == `TIMER_W'(`SETTLE_CYCLES - 1))
        begin
          next_timer = `TIMER_W'(0);
          next_sclk = 1'b1;
          next_state = adc_pkg::HOST_CLK_HI;
        end
      end
      adc_pkg::HOST_CLK_HI:
      begin
        if (timer == `TIMER_W'(`SCLK_HALF_CYCLES - 1))
        begin
          next_timer = `TIMER_W'(0);
          next_sclk = 1'b0;
          next_state = adc_pkg::HOST_CLK_LO;
          // sample just before the falling edge; the flag edge carries no data
          if (!(is_busy && edges == `EDGE_W'(0)))
          begin
            next_shift = {shift[`RESULT_MSB-1:0], res_s};
            next_bitcnt = bitcnt + 4'h1;
            if (bitcnt == 4'hF)
            begin
              next_word = {shift[`RESULT_MSB-1:0], res_s};
              next_word_valid = 1'b1;
            end
          end
        end
      end
      adc_pkg::HOST_CLK_LO:
      begin
        if (timer == `TIMER_W'(`SCLK_HALF_CYCLES - 1))
        begin
          next_timer = `TIMER_W'(0);
          next_edges = edges + `EDGE_W'(1);
          if (edges == total - `EDGE_W'(1))
          begin
            next_conv = 1'b0;
            next_sel = 1'b1;
            next_busy = 1'b0;
            next_state = adc_pkg::HOST_IDLE;
          end
          else
          begin
            next_sclk = 1'b1;
            next_state = adc_pkg::HOST_CLK_HI;
          end
        end
      end
      default:
      begin
        next_state = adc_pkg::HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      res_sync <= 2'h3;
      state <= adc_pkg::HOST_IDLE;
      mode <= adc_pkg::MODE_CS_NOBUSY;
      timer <= 16'h0000;
      edges <= 6'h00;
      bitcnt <= 4'h0;
      shift <= 16'h0000;
      word_o <= 16'h0000;
      word_valid_o <= 1'b0;
      busy_o <= 1'b0;
      conv <= 1'b0;
      sclk <= 1'b0;
      sel <= 1'b1;
    end
    else if (ce_i)
    begin
      res_sync <= next_res_sync;
      state <= next_state;
      mode <= next_mode;
      timer <= next_timer;
      edges <= next_edges;
      bitcnt <= next_bitcnt;
      shift <= next_shift;
      word_o <= next_word;
      word_valid_o <= next_word_valid;
      busy_o <= next_busy;
      conv <= next_conv;
      sclk <= next_sclk;
      sel <= next_sel;
    end
  end

  assign link.conv_trigger = conv;
  assign link.sclk = sclk;
  assign link.chain_select_in = sel;

endmodule : adc_host

// ### tb/adc_serial_readout_modes_chk.sv
`include "adc_cfg.svh"

module adc_serial_readout_modes_chk #(
  parameter int CONV_CYCLES = `CONV_CYCLES
) (
  input wire logic clk_sys_i, // system clock
  input wire logic rst_n_i, // sync reset, active low
  input wire logic conv_trigger, // host trigger
  input wire logic sclk, // serial clock
  input wire logic chain_select_in, // select or upstream data
  input wire logic result_out, // device data
  input wire logic result_out_oe // device drive enable
);
  timeunit 1ns;
  timeprecision 100ps;
  logic conv_q, next_conv_q;
  logic sclk_q, next_sclk_q;
  logic cs, next_cs;
  logic chain, next_chain;
  logic chain_busy, next_chain_busy;
  logic cs_busy, next_cs_busy;
  logic [15:0] since, next_since;
  logic [5:0] falls, next_falls;

  // mode tracking from pin levels at the trigger rise; cs and chain cleared when the trigger drops, busy flags kept
  always_comb
  begin
    next_conv_q = conv_trigger;
    next_sclk_q = sclk;
    next_cs = cs;
    next_chain = chain;
    next_chain_busy = chain_busy;
    next_cs_busy = cs_busy;
    next_since = (since == 16'hFFFF) ? since : since + 16'h0001;
    next_falls = falls;
    if (conv_q && !conv_trigger)
    begin
      next_cs = 1'b0;
      next_chain = 1'b0;
    end
    if (conv_trigger && !conv_q)
    begin
      next_cs = chain_select_in;
      next_chain = !chain_select_in;
      next_chain_busy = sclk;
      next_cs_busy = 1'b0;
      next_since = 16'h0000;
      next_falls = 6'h00;
    end
    else if (sclk_q && !sclk && conv_trigger)
      next_falls = falls + 6'h01;
    // busy choice in select mode is the select level once conversion is over
    if (int'(since) == CONV_CYCLES + 6)
      next_cs_busy = !chain_select_in;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      {conv_q, sclk_q, cs, chain, chain_busy, cs_busy} <= 6'h00;
      since <= 16'h0000;
      falls <= 6'h00;
    end
    else
    begin
      {conv_q, sclk_q, cs, chain} <= {next_conv_q, next_sclk_q, next_cs, next_chain};
      {chain_busy, cs_busy} <= {next_chain_busy, next_cs_busy};
      since <= next_since;
      falls <= next_falls;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  // slack of six cycles covers input sync and output register
  property p_cs_float;
    cs && conv_trigger && int'(since) >= 6 && int'(since) <= CONV_CYCLES |-> !result_out_oe;
  endproperty
  a_cs_float: assert property (p_cs_float)
    else $error("output driven during select-mode conversion");
  property p_low_drive;
    (!conv_trigger && !chain_select_in) [*6] |-> result_out_oe && !result_out;
  endproperty
  a_low_drive: assert property (p_low_drive)
    else $error("output not driven low with trigger and select low");
  property p_nobusy_end;
    cs && !cs_busy && $fell(sclk) && falls == 6'h0F |-> ##[1:6] !result_out_oe;
  endproperty
  a_nobusy_end: assert property (p_nobusy_end)
    else $error("output not released after sixteenth fall");
  property p_nobusy_hold;
    cs && !cs_busy && $fell(sclk) && falls == 6'h0E |=> result_out_oe [*6];
  endproperty
  a_nobusy_hold: assert property (p_nobusy_hold)
    else $error("output released early without busy flag");
  property p_busy_ready;
    cs && !chain_select_in && int'(since) == CONV_CYCLES + 6 |-> result_out_oe && !result_out;
  endproperty
  a_busy_ready: assert property (p_busy_ready)
    else $error("ready flag missing at conversion end");
  property p_busy_end;
    cs && cs_busy && $fell(sclk) && falls == 6'h10 |-> ##[1:6] !result_out_oe;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("output not released after seventeenth fall");
  property p_busy_hold;
    cs && cs_busy && $fell(sclk) && falls == 6'h0F |=> result_out_oe [*6];
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("output released early with busy flag");
  property p_chain_driven;
    chain && conv_trigger |-> result_out_oe;
  endproperty
  a_chain_driven: assert property (p_chain_driven)
    else $error("output floated in chain mode");
  property p_chain_busy_wait;
    chain && chain_busy && int'(since) <= CONV_CYCLES |-> !result_out;
  endproperty
  a_chain_busy_wait: assert property (p_chain_busy_wait)
    else $error("chain busy shown before conversion end");

  c_cs_nobusy: cover property (cs && !cs_busy && falls == 6'h10);
  c_cs_busy: cover property (cs && cs_busy && falls == 6'h11);
  c_chain_nobusy: cover property (chain && !chain_busy && falls >= 6'h20);
  c_chain_busy: cover property (chain && chain_busy && falls >= 6'h21);
endmodule : adc_serial_readout_modes_chk

// ### tb/adc_serial_readout_modes_bench.sv
`define CHECK(what, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module adc_serial_readout_modes_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DEV_CONV = 20; // shortened; host wait must stay longer
  localparam int HOST_CONV = 30;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic start_i = 1'b0;
  adc_pkg::mode_type mode_i = adc_pkg::MODE_CS_NOBUSY;
  logic [15:0] sample_i = 16'h0000;
  logic converting_o;
  logic busy_o;
  logic [15:0] word_o;
  logic word_valid_o;
  logic sclk_q = 1'b0;
  logic [15:0] lfsr = 16'h0032;
  logic [15:0] got[$];
  int n_errors = 0;
  int checked = 0;
  int falls = 0;
  int conv_len = 0;

  adc_link_if link();

  adc_device #(.CONV_CYCLES(DEV_CONV)) u_adc_device (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .sample_i(sample_i),
    .converting_o(converting_o),
    .link(link)
  );

  adc_host #(.CONV_MAX_CYCLES(HOST_CONV)) u_adc_host (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .start_i(start_i),
    .mode_i(mode_i),
    .busy_o(busy_o),
    .word_o(word_o),
    .word_valid_o(word_valid_o),
    .link(link)
  );

  adc_serial_readout_modes_chk #(.CONV_CYCLES(DEV_CONV)) u_chk (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .conv_trigger(link.conv_trigger),
    .sclk(link.sclk),
    .chain_select_in(link.chain_select_in),
    .result_out(link.result_out),
    .result_out_oe(link.result_out_oe)
  );

  always #2.5 clk_sys_i = ~clk_sys_i;

  // wire watcher; the chain-busy setup fall lands mid-conversion and is skipped
  always @(negedge clk_sys_i)
  begin
    sclk_q <= link.sclk;
    if (busy_o && link.conv_trigger && !converting_o && sclk_q && !link.sclk)
      falls++;
    if (converting_o)
      conv_len++;
    if (word_valid_o)
      got.push_back(word_o);
  end

  function automatic logic [15:0] next_rand(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : next_rand

  // sixteen per word, one more leading flag edge with busy indication
  function automatic int exp_falls(input adc_pkg::mode_type m);
    int n;
    n = (m == adc_pkg::MODE_CHAIN_NOBUSY || m == adc_pkg::MODE_CHAIN_BUSY) ? 32 : 16;
    return (m == adc_pkg::MODE_CS_BUSY || m == adc_pkg::MODE_CHAIN_BUSY) ? n + 1 : n;
  endfunction : exp_falls

  task automatic final_report();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  // one transfer; poke fires a second start while busy, which must be ignored
  task automatic xfer(input adc_pkg::mode_type m, input logic [15:0] s, input bit poke);
    int n;
    @(negedge clk_sys_i);
    sample_i = s;
    mode_i = m;
    start_i = 1'b1;
    falls = 0;
    conv_len = 0;
    got.delete();
    @(negedge clk_sys_i);
    start_i = 1'b0;
    if (poke)
    begin
      repeat (40) @(negedge clk_sys_i);
      mode_i = adc_pkg::MODE_CHAIN_BUSY;
      start_i = 1'b1;
      @(negedge clk_sys_i);
      start_i = 1'b0;
      mode_i = m;
      // both ends share the enable, so a pause must not disturb the word
      ce_i = 1'b0;
      repeat (5) @(negedge clk_sys_i);
      ce_i = 1'b1;
    end
    n = 0;
    while (busy_o !== 1'b0 && n < 5000)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    repeat (2) @(negedge clk_sys_i);
    if (n >= 5000)
    begin
      n_errors++;
      final_report();
    end
    `CHECK("word count", exp_falls(m) / 16, got.size())
    if (got.size() > 0)
      `CHECK("first word", s, got[0])
    if (got.size() > 1)
      `CHECK("second word", (m == adc_pkg::MODE_CHAIN_BUSY) ? 16'hFFFF : 16'h0000, got[1])
    `CHECK("readout falls", exp_falls(m), falls)
    `CHECK("conv length", 1'b1, conv_len >= DEV_CONV && conv_len <= DEV_CONV + 1)
    `CHECK("idle sclk", 1'b0, link.sclk)
    $display("test done mode %0d sample %h", m, s);
  endtask : xfer

  // corners per mode, then random words in random modes back to back
  initial
  begin
    repeat (2) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    for (int k = 0; k < 4; k++)
    begin
      xfer(adc_pkg::mode_type'(k), 16'h8001, k == 0);
      xfer(adc_pkg::mode_type'(k), 16'h7FFE, 1'b0);
      xfer(adc_pkg::mode_type'(k), 16'h0000, 1'b0);
      xfer(adc_pkg::mode_type'(k), 16'hFFFF, 1'b0);
    end
    repeat (12)
    begin
      lfsr = next_rand(lfsr);
      xfer(adc_pkg::mode_type'(lfsr[1:0]), lfsr, 1'b0);
    end
    final_report();
  end
endmodule : adc_serial_readout_modes_bench
